/* logic/slic_cal_defs.svh */
// register offsets, field layouts, reset values and timing counts
`ifndef SLIC_CAL_DEFS_SVH
`define SLIC_CAL_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TIP_MISMATCH_ADDR 8'h63
`define DIFF_GAIN_ADDR 8'h64
`define CM_GAIN_ADDR 8'h65
`define LIMIT_CAL_ADDR 8'h66
`define MONITOR_OFFSET_ADDR 8'h67
`define CONVERTER_OFFSET_ADDR 8'h68
`define AUDIO_DAC_OFFSET_ADDR 8'h69
`define BALANCE_ADDR 8'h6A
`define PEAK_MONITOR_ADDR 8'h6B
`define ENHANCE_ADDR 8'h6C

// ****************************************************************
// reset values
// ****************************************************************
`define TIP_MISMATCH_RST 5'h10
`define DIFF_GAIN_RST 5'h00
`define CM_GAIN_RST 5'h11
`define LIMIT_CAL_RST 4'h8
`define MONITOR_OFFSET_RST 8'h00
`define CONVERTER_OFFSET_RST 4'h0
`define AUDIO_DAC_OFFSET_RST 8'h00
`define BALANCE_RST 6'h00
`define PEAK_MONITOR_RST 4'h8
`define ENHANCE_RST 8'h00

// ****************************************************************
// enhancement enable bit positions and writable mask
// ****************************************************************
`define ENH_LIMIT_BOOST 7
`define ENH_TONE_ENHANCE 6
`define ENH_SPEEDUP 5
`define ENH_EXT_REF 4
`define ENH_VOLTAGE_CLOSURE 2
`define ENH_SQUELCH 1
`define ENH_HYSTERESIS 0
`define ENH_WRITE_MASK 8'hF7

// ****************************************************************
// analog offset bit positions
// ****************************************************************
`define DAC_OFFSET_POS_BIT 3
`define DAC_OFFSET_NEG_BIT 2
`define ADC_OFFSET_POS_BIT 1
`define ADC_OFFSET_NEG_BIT 0

// ****************************************************************
// loop current limits in mA
// ****************************************************************
`define LIMIT_BASE_MA 6'h14
`define LIMIT_STEP_MA 6'h03
`define LIMIT_BOOST_MA 6'h29

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 100000000
`define CLK_MHZ 100
`define TONE_NORMAL_HZ 8000
`define TONE_FSK_HZ 24000
`define BOOST_TIME_US 1000

`endif

/* logic/slic_cal_pkg.sv */
// types shared by the calibration and enhancement register bank
package slic_cal_pkg;

  typedef enum logic {boost_idle, boost_hold} boost_state_type;

  typedef struct packed {
    logic [4:0] tip_mismatch_result;
    logic [4:0] diff_gain_result;
    logic [4:0] cm_gain_result;
    logic [3:0] limit_cal_result;
    logic [7:0] monitor_offset;
    logic [3:0] converter_offset;
    logic [7:0] audio_dac_offset_value;
    logic [5:0] longitudinal_balance_result;
    logic [3:0] peak_monitor_result;
    logic [7:0] enhance;
    logic [7:0] rdata;
    logic rvalid;
    boost_state_type boost;
    logic [16:0] boost_cnt;
    logic [5:0] limit_ma;
    logic loop_closed;
  } bank_state_type;

  typedef struct packed {
    logic [13:0] cnt;
    logic tick;
  } tick_state_type;

endpackage

/* logic/tone_tick_gen.sv */
// tone generator sample tick at normal or enhanced rate
`timescale 1ns/100ps
`include "slic_cal_defs.svh"

module tone_tick_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic fast,
  input wire logic [13:0] normal_div,
  input wire logic [13:0] fast_div,
  output logic tick
);

  slic_cal_pkg::tick_state_type q;
  slic_cal_pkg::tick_state_type d;

  // ****************************************************************
  // divider
  // ****************************************************************
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 14'h0000) begin
      d.cnt = fast ? fast_div - 14'h0001 : normal_div - 14'h0001;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - 14'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_tick_single;
    tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("tone tick longer than one cycle");

endmodule

/* logic/cal_enhance_regs.sv */
// calibration result and enhancement enable register bank
`timescale 1ns/100ps
`include "slic_cal_defs.svh"

module cal_enhance_regs #(
  parameter int NORMAL_DIV = `CLK_HZ / `TONE_NORMAL_HZ,
  parameter int FSK_DIV = `CLK_HZ / `TONE_FSK_HZ,
  parameter int BOOST_CYCLES = `BOOST_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic ring_burst_end,
  input wire logic [2:0] programmed_loop_limit,
  input wire logic linefeed_reversal_bit,
  input wire logic loop_current_closed,
  input wire logic loop_voltage_closed,
  output logic [5:0] loop_limit_ma,
  output logic limit_boost_active,
  output logic tone_tick,
  output logic osc_timer_tick,
  output logic tone_rate_fast,
  output logic fsk_registers_select,
  output logic converter_speedup,
  output logic impedance_ext_ref,
  output logic dc_squelch,
  output logic closure_hysteresis,
  output logic loop_closed
);

  slic_cal_pkg::bank_state_type q;
  slic_cal_pkg::bank_state_type d;
  logic fsk_active;
  logic boost_next;

  // ****************************************************************
  // register writes, reads and enhancement state
  // ****************************************************************
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `TIP_MISMATCH_ADDR: d.tip_mismatch_result = reg_wdata[4:0];
        `DIFF_GAIN_ADDR: d.diff_gain_result = reg_wdata[4:0];
        `CM_GAIN_ADDR: d.cm_gain_result = reg_wdata[4:0];
        `LIMIT_CAL_ADDR: d.limit_cal_result = reg_wdata[3:0];
        `MONITOR_OFFSET_ADDR: d.monitor_offset = reg_wdata;
        `CONVERTER_OFFSET_ADDR: d.converter_offset = reg_wdata[3:0];
        `AUDIO_DAC_OFFSET_ADDR: d.audio_dac_offset_value = reg_wdata;
        `BALANCE_ADDR: d.longitudinal_balance_result = reg_wdata[5:0];
        `PEAK_MONITOR_ADDR: d.peak_monitor_result = reg_wdata[3:0];
        `ENHANCE_ADDR: d.enhance = reg_wdata & `ENH_WRITE_MASK;
        default: d.enhance = d.enhance;
      endcase
    end
    if (reg_rd) begin
      d.rvalid = 1'b1;
      case (reg_addr)
        `TIP_MISMATCH_ADDR: d.rdata = {3'h0, q.tip_mismatch_result};
        `DIFF_GAIN_ADDR: d.rdata = {3'h0, q.diff_gain_result};
        `CM_GAIN_ADDR: d.rdata = {3'h0, q.cm_gain_result};
        `LIMIT_CAL_ADDR: d.rdata = {4'h0, q.limit_cal_result};
        `MONITOR_OFFSET_ADDR: d.rdata = q.monitor_offset;
        `CONVERTER_OFFSET_ADDR: d.rdata = {4'h0, q.converter_offset};
        `AUDIO_DAC_OFFSET_ADDR: d.rdata = q.audio_dac_offset_value;
        `BALANCE_ADDR: d.rdata = {2'h0, q.longitudinal_balance_result};
        `PEAK_MONITOR_ADDR: d.rdata = {4'h0, q.peak_monitor_result};
        `ENHANCE_ADDR: d.rdata = q.enhance;
        default: d.rdata = 8'h00;
      endcase
    end

    case (q.boost)
      slic_cal_pkg::boost_idle: begin
        if (ring_burst_end && q.enhance[`ENH_LIMIT_BOOST]) begin
          d.boost = slic_cal_pkg::boost_hold;
          d.boost_cnt = 17'(BOOST_CYCLES - 1);
        end
      end
      slic_cal_pkg::boost_hold: begin
        if (!d.enhance[`ENH_LIMIT_BOOST]) begin
          d.boost = slic_cal_pkg::boost_idle;
        end else if (ring_burst_end) begin
          d.boost_cnt = 17'(BOOST_CYCLES - 1);
        end else if (q.boost_cnt == 17'h00000) begin
          d.boost = slic_cal_pkg::boost_idle;
        end else begin
          d.boost_cnt = q.boost_cnt - 17'h00001;
        end
      end
      default: d.boost = slic_cal_pkg::boost_idle;
    endcase

    boost_next = (d.boost == slic_cal_pkg::boost_hold) &&
                 d.enhance[`ENH_LIMIT_BOOST];
    if (boost_next) begin
      d.limit_ma = `LIMIT_BOOST_MA;
    end else begin
      d.limit_ma = `LIMIT_BASE_MA +
                   ({3'h0, programmed_loop_limit} * `LIMIT_STEP_MA);
    end

    d.loop_closed = q.enhance[`ENH_VOLTAGE_CLOSURE] ?
                    loop_voltage_closed : loop_current_closed;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.tip_mismatch_result <= `TIP_MISMATCH_RST;
      q.diff_gain_result <= `DIFF_GAIN_RST;
      q.cm_gain_result <= `CM_GAIN_RST;
      q.limit_cal_result <= `LIMIT_CAL_RST;
      q.monitor_offset <= `MONITOR_OFFSET_RST;
      q.converter_offset <= `CONVERTER_OFFSET_RST;
      q.audio_dac_offset_value <= `AUDIO_DAC_OFFSET_RST;
      q.longitudinal_balance_result <= `BALANCE_RST;
      q.peak_monitor_result <= `PEAK_MONITOR_RST;
      q.enhance <= `ENHANCE_RST;
      q.rdata <= 8'h00;
      q.rvalid <= 1'b0;
      q.boost <= slic_cal_pkg::boost_idle;
      q.boost_cnt <= 17'h00000;
      q.limit_ma <= `LIMIT_BASE_MA;
      q.loop_closed <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // tone clock and feature outputs
  // ****************************************************************
  // fast only with reversal
  assign fsk_active = q.enhance[`ENH_TONE_ENHANCE] && linefeed_reversal_bit;

  tone_tick_gen tick_gen (
    .clk(clk),
    .rst(rst),
    .fast(fsk_active),
    .normal_div(14'(NORMAL_DIV)),
    .fast_div(14'(FSK_DIV)),
    .tick(tone_tick)
  );

  assign osc_timer_tick = tone_tick;
  assign tone_rate_fast = fsk_active;
  assign fsk_registers_select = fsk_active;
  assign converter_speedup = q.enhance[`ENH_SPEEDUP];
  assign impedance_ext_ref = q.enhance[`ENH_EXT_REF];
  assign dc_squelch = q.enhance[`ENH_SQUELCH];
  assign closure_hysteresis = q.enhance[`ENH_HYSTERESIS];
  assign limit_boost_active = (q.boost == slic_cal_pkg::boost_hold) &&
                              q.enhance[`ENH_LIMIT_BOOST];
  assign loop_limit_ma = q.limit_ma;
  assign loop_closed = q.loop_closed;
  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write(logic [7:0] a);
    reg_wr && !reg_rd && reg_addr == a;
  endsequence

  sequence s_read(logic [7:0] a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence

  property p_tip_store;
    s_write(`TIP_MISMATCH_ADDR) |=>
      q.tip_mismatch_result == $past(reg_wdata[4:0]);
  endproperty
  a_tip_store: assert property (p_tip_store)
    else $error("TIP mismatch field not stored");

  property p_diff_read;
    s_read(`DIFF_GAIN_ADDR) |=>
      reg_rvalid && reg_rdata == {3'h0, $past(q.diff_gain_result)};
  endproperty
  a_diff_read: assert property (p_diff_read)
    else $error("differential gain read wrong");

  property p_cm_roundtrip;
    s_write(`CM_GAIN_ADDR) ##1 s_read(`CM_GAIN_ADDR) |=>
      reg_rdata == {3'h0, $past(reg_wdata[4:0], 2)};
  endproperty
  a_cm_roundtrip: assert property (p_cm_roundtrip)
    else $error("common-mode gain round trip wrong");

  property p_limit_read;
    s_read(`LIMIT_CAL_ADDR) |=>
      reg_rdata == {4'h0, $past(q.limit_cal_result)};
  endproperty
  a_limit_read: assert property (p_limit_read)
    else $error("limit result read wrong");

  property p_monitor_roundtrip;
    s_write(`MONITOR_OFFSET_ADDR) ##1 s_read(`MONITOR_OFFSET_ADDR) |=>
      reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_monitor_roundtrip: assert property (p_monitor_roundtrip)
    else $error("monitor offset nibbles wrong");

  property p_offset_read;
    s_read(`CONVERTER_OFFSET_ADDR) |=>
      reg_rdata[7:4] == 4'h0 &&
      reg_rdata[`DAC_OFFSET_POS_BIT] ==
        $past(q.converter_offset[`DAC_OFFSET_POS_BIT]) &&
      reg_rdata[`ADC_OFFSET_NEG_BIT] ==
        $past(q.converter_offset[`ADC_OFFSET_NEG_BIT]);
  endproperty
  a_offset_read: assert property (p_offset_read)
    else $error("analog offset bits read wrong");

  property p_audio_store;
    s_write(`AUDIO_DAC_OFFSET_ADDR) |=>
      q.audio_dac_offset_value == $past(reg_wdata);
  endproperty
  a_audio_store: assert property (p_audio_store)
    else $error("audio DAC offset not stored");

  property p_balance_read;
    s_read(`BALANCE_ADDR) |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_balance_read: assert property (p_balance_read)
    else $error("balance reserved bits not zero");

  property p_peak_store;
    s_write(`PEAK_MONITOR_ADDR) |=>
      q.peak_monitor_result == $past(reg_wdata[3:0]);
  endproperty
  a_peak_store: assert property (p_peak_store)
    else $error("peak monitor result not stored");

  property p_boost_start;
    ring_burst_end && q.enhance[`ENH_LIMIT_BOOST] && !reg_wr |=>
      limit_boost_active && loop_limit_ma == `LIMIT_BOOST_MA;
  endproperty
  a_boost_start: assert property (p_boost_start)
    else $error("limit boost missing after ring burst");

  property p_no_boost;
    !q.enhance[`ENH_LIMIT_BOOST] && !reg_wr |=>
      loop_limit_ma == `LIMIT_BASE_MA +
        ({3'h0, $past(programmed_loop_limit)} * `LIMIT_STEP_MA);
  endproperty
  a_no_boost: assert property (p_no_boost)
    else $error("programmed limit not used");

  // reload value shows which rate the divider took
  property p_fast_rate;
    tone_tick && $past(tone_rate_fast) |->
      tick_gen.q.cnt == 14'(FSK_DIV - 1);
  endproperty
  a_fast_rate: assert property (p_fast_rate)
    else $error("tone divider reload wrong at fast rate");

  property p_param_set;
    fsk_registers_select |-> q.enhance[`ENH_TONE_ENHANCE];
  endproperty
  a_param_set: assert property (p_param_set)
    else $error("dedicated parameter set without enhancement");

  property p_slow_rate;
    tone_tick && !$past(tone_rate_fast) |->
      tick_gen.q.cnt == 14'(NORMAL_DIV - 1);
  endproperty
  a_slow_rate: assert property (p_slow_rate)
    else $error("tone divider reload wrong at normal rate");

  property p_speedup;
    s_write(`ENHANCE_ADDR) |=>
      converter_speedup == $past(reg_wdata[`ENH_SPEEDUP]);
  endproperty
  a_speedup: assert property (p_speedup)
    else $error("speedup select not following register");

  property p_closure;
    1'b1 |=> loop_closed == ($past(q.enhance[`ENH_VOLTAGE_CLOSURE]) ?
      $past(loop_voltage_closed) : $past(loop_current_closed));
  endproperty
  a_closure: assert property (p_closure)
    else $error("loop closure source wrong");

  property p_enh_reserved;
    s_write(`ENHANCE_ADDR) |=> q.enhance[3] == 1'b0;
  endproperty
  a_enh_reserved: assert property (p_enh_reserved)
    else $error("reserved enhancement bit stored");

  property p_boost_expire;
    limit_boost_active && q.boost_cnt == 17'h00000 && !ring_burst_end |=>
      !limit_boost_active;
  endproperty
  a_boost_expire: assert property (p_boost_expire)
    else $error("limit boost outlasts its hold time");

  property p_tip_reserved;
    s_read(`TIP_MISMATCH_ADDR) |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_tip_reserved: assert property (p_tip_reserved)
    else $error("TIP mismatch reserved bits not zero");

  property p_unmapped_read;
    reg_rd && !reg_wr &&
      (reg_addr < `TIP_MISMATCH_ADDR || reg_addr > `ENHANCE_ADDR) |=>
      reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

endmodule

/* logic/empty_placeholder_none.sv */
// intentionally minimal: no further design logic

/* testbench/host_port_model.sv */
// host processor model driving the parallel register port
`timescale 1ns/100ps

module host_port_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // one-cycle write strobe; released lines show inverted values
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  // one-cycle read strobe, answer awaited for a few cycles only
  task automatic read(input logic [7:0] addr, output logic [7:0] data,
                      output logic ok);
    int i;
    ok = 1'b0;
    data = 8'h00;
    @(negedge clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    for (i = 0; i < 4 && ok == 1'b0; i++) begin
      if (reg_rvalid === 1'b1) begin
        data = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask

  // write then read of one address on two neighbouring edges
  task automatic write_read(input logic [7:0] addr, input logic [7:0] data,
                            output logic [7:0] rdata, output logic ok);
    int i;
    ok = 1'b0;
    rdata = 8'h00;
    @(negedge clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
    for (i = 0; i < 4 && ok == 1'b0; i++) begin
      if (reg_rvalid === 1'b1) begin
        rdata = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule

/* testbench/calibration_result_enhancement_regs_tb.sv */
// self-checking bench for the calibration and enhancement bank
`timescale 1ns/100ps
`include "slic_cal_defs.svh"

module calibration_result_enhancement_regs_tb;
  logic clk, rst, reg_wr, reg_rd, reg_rvalid, ring_burst_end;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] programmed_loop_limit;
  logic linefeed_reversal_bit, loop_current_closed, loop_voltage_closed;
  logic [5:0] loop_limit_ma;
  logic limit_boost_active, tone_tick, osc_timer_tick, tone_rate_fast;
  logic fsk_registers_select, converter_speedup, impedance_ext_ref;
  logic dc_squelch, closure_hysteresis, loop_closed;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] rst_v [10] = '{8'h10, 8'h00, 8'h11, 8'h08, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [7:0] mask_v [10] = '{8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'hFF,
                              8'h0F, 8'hFF, 8'h3F, 8'h0F, 8'hF7};
  logic [7:0] pat_v [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h00};

  cal_enhance_regs #(.NORMAL_DIV(8), .FSK_DIV(4), .BOOST_CYCLES(10)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ring_burst_end(ring_burst_end),
    .programmed_loop_limit(programmed_loop_limit),
    .linefeed_reversal_bit(linefeed_reversal_bit),
    .loop_current_closed(loop_current_closed),
    .loop_voltage_closed(loop_voltage_closed),
    .loop_limit_ma(loop_limit_ma), .limit_boost_active(limit_boost_active),
    .tone_tick(tone_tick), .osc_timer_tick(osc_timer_tick),
    .tone_rate_fast(tone_rate_fast),
    .fsk_registers_select(fsk_registers_select),
    .converter_speedup(converter_speedup),
    .impedance_ext_ref(impedance_ext_ref), .dc_squelch(dc_squelch),
    .closure_hysteresis(closure_hysteresis), .loop_closed(loop_closed));

  host_port_model host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic stop_test;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic timeout;
    n_errors++;
    stop_test();
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    host.read(a, d, ok);
    if (ok !== 1'b1) timeout();
  endtask

  task automatic wait_tick;
    int i;
    for (i = 0; i < 40 && tone_tick !== 1'b1; i++) @(negedge clk);
    if (tone_tick !== 1'b1) timeout();
  endtask

  // cycles from one tone tick to the next
  task automatic tick_period(output logic [7:0] p);
    int i;
    p = 8'h00;
    wait_tick();
    for (i = 1; i <= 40 && p == 8'h00; i++) begin
      @(negedge clk);
      if (tone_tick === 1'b1) p = 8'(i);
    end
    chk({7'h00, osc_timer_tick}, 8'h01);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_values;
    logic [7:0] d;
    for (int i = 0; i < 10; i++) begin
      rd(8'h63 + 8'(i), d);
      chk(d, rst_v[i]);
    end
  endtask

  // all registers written first, then read back through the masks
  task automatic t_field_masks;
    logic [7:0] d;
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 10; i++) host.write(8'h63 + 8'(i), pat_v[p]);
      for (int i = 0; i < 10; i++) begin
        rd(8'h63 + 8'(i), d);
        chk(d, pat_v[p] & mask_v[i]);
      end
    end
    host.write(`CONVERTER_OFFSET_ADDR, 8'hF6);
    rd(`CONVERTER_OFFSET_ADDR, d);
    chk(d, 8'h06);
    host.write(`BALANCE_ADDR, 8'hEA);
    rd(`BALANCE_ADDR, d);
    chk(d, 8'h2A);
  endtask

  task automatic t_unmapped;
    logic [7:0] d;
    host.write(`TIP_MISMATCH_ADDR, 8'h05);
    host.write(8'h62, 8'hFF);
    host.write(8'h6D, 8'hFF);
    rd(8'h62, d);
    chk(d, 8'h00);
    rd(8'h6D, d);
    chk(d, 8'h00);
    rd(`TIP_MISMATCH_ADDR, d);
    chk(d, 8'h05);
  endtask

  // write and read on neighbouring edges
  task automatic t_roundtrip;
    logic [7:0] d;
    logic ok;
    host.write_read(`CM_GAIN_ADDR, 8'hEE, d, ok);
    if (ok !== 1'b1) timeout();
    chk(d, 8'h0E);
    host.write_read(`MONITOR_OFFSET_ADDR, 8'h3C, d, ok);
    if (ok !== 1'b1) timeout();
    chk(d, 8'h3C);
  endtask

  task automatic t_enhance_levels;
    host.write(`ENHANCE_ADDR, 8'h20);
    chk({4'h0, converter_speedup, impedance_ext_ref, dc_squelch,
         closure_hysteresis}, 8'h08);
    host.write(`ENHANCE_ADDR, 8'h13);
    chk({4'h0, converter_speedup, impedance_ext_ref, dc_squelch,
         closure_hysteresis}, 8'h07);
  endtask

  task automatic t_closure;
    host.write(`ENHANCE_ADDR, 8'h00);
    loop_current_closed = 1'b1;
    loop_voltage_closed = 1'b0;
    @(negedge clk);
    chk({7'h00, loop_closed}, 8'h01);
    host.write(`ENHANCE_ADDR, 8'h04);
    @(negedge clk);
    chk({7'h00, loop_closed}, 8'h00);
    loop_current_closed = 1'b0;
    loop_voltage_closed = 1'b1;
    @(negedge clk);
    chk({7'h00, loop_closed}, 8'h01);
  endtask

  task automatic pulse_burst;
    @(negedge clk);
    ring_burst_end = 1'b1;
    @(negedge clk);
    ring_burst_end = 1'b0;
  endtask

  task automatic t_boost;
    programmed_loop_limit = 3'h3;
    host.write(`ENHANCE_ADDR, 8'h00);
    pulse_burst();
    chk({limit_boost_active, 1'b0, loop_limit_ma}, 8'h1D);
    host.write(`ENHANCE_ADDR, 8'h80);
    pulse_burst();
    chk({limit_boost_active, 1'b0, loop_limit_ma}, 8'hA9);
    repeat (8) @(negedge clk);
    chk({limit_boost_active, 1'b0, loop_limit_ma}, 8'hA9);
    @(negedge clk);
    chk({limit_boost_active, 1'b0, loop_limit_ma}, 8'hA9);
    @(negedge clk);
    chk({limit_boost_active, 1'b0, loop_limit_ma}, 8'h1D);
    pulse_burst();
    host.write(`ENHANCE_ADDR, 8'h00);
    @(negedge clk);
    chk({limit_boost_active, 1'b0, loop_limit_ma}, 8'h1D);
  endtask

  // reset in mid-run brings every field back
  task automatic t_mid_reset;
    for (int i = 0; i < 10; i++) host.write(8'h63 + 8'(i), 8'hFF);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset_values();
  endtask

  task automatic t_tone_rate;
    logic [7:0] p;
    linefeed_reversal_bit = 1'b1;
    host.write(`ENHANCE_ADDR, 8'h00);
    tick_period(p);
    tick_period(p);
    chk(p, 8'h08);
    chk({6'h00, tone_rate_fast, fsk_registers_select}, 8'h00);
    linefeed_reversal_bit = 1'b0;
    host.write(`ENHANCE_ADDR, 8'h40);
    tick_period(p);
    tick_period(p);
    chk(p, 8'h08);
    chk({6'h00, tone_rate_fast, fsk_registers_select}, 8'h00);
    linefeed_reversal_bit = 1'b1;
    @(negedge clk);
    chk({6'h00, tone_rate_fast, fsk_registers_select}, 8'h03);
    tick_period(p);
    tick_period(p);
    chk(p, 8'h04);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    ring_burst_end = 1'b0;
    programmed_loop_limit = 3'h0;
    linefeed_reversal_bit = 1'b0;
    loop_current_closed = 1'b0;
    loop_voltage_closed = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset_values();
    t_field_masks();
    t_unmapped();
    t_roundtrip();
    t_enhance_levels();
    t_closure();
    t_boost();
    t_tone_rate();
    t_mid_reset();
    stop_test();
  end
endmodule
